// File: src/int_err_pkg.sv
// Package with constants and carriers for the per-port internal error block
package int_err_pkg;

	// Status bit positions, one per internal error source
	localparam int SRC_W          = 7;
	localparam int SRC_TIMEOUT    = 0;
	localparam int SRC_IFB_CTL    = 1;
	localparam int SRC_IFB_DATA   = 2;
	localparam int SRC_EFB_CTL    = 3;
	localparam int SRC_EFB_DATA   = 4;
	localparam int SRC_RPLY_CTL   = 5;
	localparam int SRC_E2E_PARITY = 6;
	localparam int MEM_N          = 5;

	// Register map, word addresses on the plain register port
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFF_CONTROL  = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_STATUS   = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_MASK     = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_SEVERITY = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_TEST     = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_AER_UEM  = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_AER_UESV = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_AER_CEM  = 4'h7;
	localparam logic [ADDR_W-1:0] OFF_AER_STS  = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_HDR_LOG  = 4'h9;
	localparam int DATA_W = 32;

	// Field positions
	localparam int CTL_ENABLE_BIT = 0;
	localparam int AER_UIE_BIT    = 22;
	localparam int AER_CIE_BIT    = 14;
	localparam int AER_HLO_BIT    = 15;

	// Reset values
	localparam logic [SRC_W-1:0]  MASK_RST     = 7'h00;
	localparam logic [SRC_W-1:0]  SEV_RST      = 7'h7f;
	localparam logic [DATA_W-1:0] AER_UEM_RST  = 32'h0040_0000;
	localparam logic [DATA_W-1:0] AER_UESV_RST = 32'h0040_0000;
	localparam logic [DATA_W-1:0] AER_CEM_RST  = 32'h0000_c000;
	localparam logic [DATA_W-1:0] HDR_ONES     = 32'hffff_ffff;
	localparam logic [DATA_W-1:0] ZERO_WORD    = 32'h0000_0000;

	// Age limit before a queued packet is discarded
	localparam longint AGE_LIMIT_S  = 64;
	localparam longint CLK_HZ       = 250_000_000;
	localparam longint AGE_LIMIT_CY = AGE_LIMIT_S * CLK_HZ;
	localparam int AGE_W = 34;

	// Per-DWord data beat with its even parity bit
	typedef struct packed {
		logic        valid;
		logic        sop;
		logic        eop;
		logic [31:0] data;
		logic        parity;
	} dw_beat_t;

	// Egress link-layer frame end controls
	typedef struct packed {
		logic valid;
		logic nullify;
		logic end_edb;
	} egr_end_t;

	// Memory error indications per port memory
	typedef struct packed {
		logic [MEM_N-1:0] single_bit;
		logic [MEM_N-1:0] double_bit;
	} mem_err_t;

endpackage

// File: src/internal_error_ecc_parity.sv
// Per-port internal error detection, classification, reporting and nullify logic
// Functional notes
// RULE1 - Time-outs, ECC single/double and parity errors are internal errors reported by port.
// RULE2 - With reporting disabled, internal-error AER mask and severity fields are read-only.
// RULE3 - Uncorrectable internal errors log an all-ones header, never a real one.
// RULE4 - One status bit per error source, set on detection.
// RULE5 - A set mask bit stops its status bit from producing a report.
// RULE6 - Severity bit picks uncorrectable or correctable; matching AER status bit is set.
// RULE7 - Writing one to a test bit sets the status bit and reports it.
// RULE8 - Packets older than 64 seconds at a queue head are discarded.
// RULE9 - A broadcast packet timing out is aborted, possibly partially sent.
// RULE10 - Memories use SECDED; single bits corrected, reporting optional.
// RULE11 - Double bit detection does not disable single bit correction.
// RULE12 - Five protected memories per port, each with its own status bit.
// RULE13 - A memory error sets the status bit of that memory.
// RULE14 - Data double bit error nullifies packet: inverted LCRC and EDB end.
// RULE15 - No replay under new sequence; double bit error in replay flushes buffer.
// RULE16 - Internally targeted packets with a double bit error are discarded.
// RULE17 - Ingress checks LCRC and computes even parity per 32-bit DWord.
// RULE18 - Parity is updated incrementally on changes, never regenerated.
// RULE19 - Egress checks parity while computing the outgoing LCRC.
// RULE20 - Egress parity error nullifies the packet and sets end-to-end parity status.
// RULE21 - Parity error during replay flushes the whole replay buffer.
// RULE22 - Generated packets get parity; consumed packets checked, discarded and flagged on error.
// RULE23 - The link partner discards nullified packets.
// RULE24 - Writing zero to a test bit leaves the status bit unchanged.
`timescale 1ns/100ps
`default_nettype none

module internal_error_ecc_parity
	import int_err_pkg::*;
#(
	// Packet age limit in core clock cycles; a bench may shorten it
	parameter longint AGE_LIMIT_CYCLES = AGE_LIMIT_CY
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	// Switch core queue heads and broadcast state
	input  wire logic              head_valid_i,
	input  wire logic [AGE_W-1:0]  head_age_i,
	input  wire logic              bcast_active_i,
	output logic                   head_discard_o,
	output logic                   bcast_abort_o,
	// Memory ECC results
	input  wire mem_err_t          mem_err_i,
	// Ingress link layer: LCRC outcome and received DWord
	input  wire dw_beat_t          ing_beat_i,
	input  wire logic              ing_lcrc_bad_i,
	output dw_beat_t               ing_beat_o,
	output logic                   ing_retry_o,
	// In-switch modification: old and new DWord for incremental parity
	input  wire logic              mod_valid_i,
	input  wire logic [31:0]       mod_old_i,
	input  wire logic [31:0]       mod_new_i,
	input  wire logic              mod_par_i,
	output logic                   mod_par_o,
	// Switch generated DWord
	input  wire logic              gen_valid_i,
	input  wire logic [31:0]       gen_data_i,
	output dw_beat_t               gen_beat_o,
	// Switch consumed packet
	input  wire dw_beat_t          con_beat_i,
	input  wire logic              con_dbe_i,
	output logic                   con_discard_o,
	// Egress link layer
	input  wire dw_beat_t          egr_beat_i,
	input  wire logic              egr_data_dbe_i,
	input  wire logic              replay_active_i,
	input  wire logic [31:0]       egr_lcrc_i,
	output egr_end_t               egr_end_o,
	output logic      [31:0]       egr_lcrc_o,
	output logic                   replay_flush_o,
	// Reports toward error reporting
	output logic                   uncor_report_o,
	output logic                   cor_report_o
);

	// Refuse an age limit that the age compare cannot hold or that discards every packet
	if (AGE_LIMIT_CYCLES < 1 || AGE_LIMIT_CYCLES >= (64'h1 << AGE_W)) begin : g_age_limit_check
		$error("AGE_LIMIT_CYCLES out of range");
	end
	// The memory loop needs the five memory bits in order after the time-out bit
	if (SRC_RPLY_CTL != SRC_IFB_CTL + MEM_N - 1 || SRC_W > DATA_W) begin : g_source_map_check
		$error("error source map does not fit");
	end

	// Age is compared in the width of the queue head's age counter
	localparam logic [AGE_W-1:0] AGE_LIM = AGE_W'(AGE_LIMIT_CYCLES);

	// Error reporting status word: one correctable and one uncorrectable flag
	localparam int AER_W         = 2;
	localparam int AER_COR_BIT   = 0;
	localparam int AER_UNCOR_BIT = 1;

	// Register state
	logic              enable_reg,   enable_next;
	logic [SRC_W-1:0]  status_reg,   status_next;
	logic [SRC_W-1:0]  mask_reg,     mask_next;
	logic [SRC_W-1:0]  sev_reg,      sev_next;
	logic [DATA_W-1:0] uem_reg,      uem_next;
	logic [DATA_W-1:0] uesv_reg,     uesv_next;
	logic [DATA_W-1:0] cem_reg,      cem_next;
	logic [AER_W-1:0]  aer_sts_reg,  aer_sts_next;
	logic [DATA_W-1:0] hdr_reg,      hdr_next;

	// Read data and report pulses
	logic [DATA_W-1:0] rdata_reg,    rdata_next;
	logic              uncor_reg,    uncor_next;
	logic              cor_reg,      cor_next;

	// Data path state
	logic              discard_reg,  discard_next;
	logic              abort_reg,    abort_next;

	// Ingress, modify, generate and consume paths
	dw_beat_t          ing_reg,      ing_next;
	logic              retry_reg,    retry_next;
	logic              modp_reg,     modp_next;
	dw_beat_t          gen_reg,      gen_next;
	logic              cdis_reg,     cdis_next;
	logic              cbad_reg,     cbad_next;

	// Egress frame state
	logic              ebad_reg,     ebad_next;
	egr_end_t          eend_reg,     eend_next;
	logic [31:0]       lcrc_reg,     lcrc_next;
	logic              flush_reg,    flush_next;

	// Detection terms
	logic              timeout;
	logic              egr_par_err;
	logic              con_par_err;
	logic [SRC_W-1:0]  detect;
	logic [SRC_W-1:0]  new_set;
	logic [SRC_W-1:0]  test_set;
	logic              egr_bad_now;
	logic              con_bad_now;

	// All event inputs come from core-clock logic, so no synchroniser stands in front
	always_comb begin
		// Age time-out at the head of a queue
		timeout = head_valid_i && (head_age_i > AGE_LIM); // see RULE8
		// Parity checks on egress and consumed beats
		egr_par_err = egr_beat_i.valid && ((^egr_beat_i.data) != egr_beat_i.parity); // see RULE19
		con_par_err = con_beat_i.valid && ((^con_beat_i.data) != con_beat_i.parity); // see RULE22
		// Source detections; either ECC grade sets the memory's bit
		detect = '0;
		detect[SRC_TIMEOUT]    = timeout; // see RULE1
		// A double bit grade may arrive with corrections as well; either one sets the bit
		for (int m = 0; m < MEM_N; m++) // see RULE12 see RULE13
			detect[SRC_IFB_CTL + m] = mem_err_i.single_bit[m] | mem_err_i.double_bit[m]; // see RULE10 see RULE11
		detect[SRC_E2E_PARITY] = egr_par_err | con_par_err; // see RULE20
		// Test writes only ever set bits; zeros are ignored
		test_set = (reg_wr_i && reg_addr_i == OFF_TEST) ? reg_wdata_i[SRC_W-1:0] : '0; // see RULE7 see RULE24
		// A frame turns bad through a parity error or a double bit error in its data
		egr_bad_now = egr_par_err | egr_data_dbe_i;
		con_bad_now = con_par_err | con_dbe_i;
	end

	// Register file, status and reporting next values
	always_comb begin
		enable_next  = enable_reg;
		mask_next    = mask_reg;
		sev_next     = sev_reg;
		uem_next     = uem_reg;
		uesv_next    = uesv_reg;
		cem_next     = cem_reg;
		hdr_next     = hdr_reg;
		aer_sts_next = aer_sts_reg;
		status_next  = status_reg;
		rdata_next   = ZERO_WORD;
		// Software clear by writing ones, applied before detections so a set wins
		if (reg_wr_i && reg_addr_i == OFF_STATUS)
			status_next = status_next & ~reg_wdata_i[SRC_W-1:0];
		// Only a 0 to 1 change reports, so a sticky bit does not report every cycle
		new_set     = (detect | test_set) & ~status_reg; // see RULE4
		status_next = status_next | detect | test_set; // see RULE4 see RULE7
		// Plain writes; internal-error bits of the reporting words hold while disabled
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				OFF_CONTROL:  enable_next = reg_wdata_i[CTL_ENABLE_BIT];
				OFF_MASK:     mask_next   = reg_wdata_i[SRC_W-1:0];
				OFF_SEVERITY: sev_next    = reg_wdata_i[SRC_W-1:0];
				OFF_AER_UEM: begin
					uem_next = reg_wdata_i;
					if (!enable_reg)
						uem_next[AER_UIE_BIT] = uem_reg[AER_UIE_BIT]; // see RULE2
				end
				OFF_AER_UESV: begin
					uesv_next = reg_wdata_i;
					if (!enable_reg)
						uesv_next[AER_UIE_BIT] = uesv_reg[AER_UIE_BIT]; // see RULE2
				end
				OFF_AER_CEM: begin
					cem_next = reg_wdata_i;
					if (!enable_reg) begin
						cem_next[AER_CIE_BIT] = cem_reg[AER_CIE_BIT]; // see RULE2
						cem_next[AER_HLO_BIT] = cem_reg[AER_HLO_BIT];
					end
				end
				// Reporting status clears by writing ones; a report in the same cycle still sets
				OFF_AER_STS:  aer_sts_next = aer_sts_next & ~reg_wdata_i[AER_W-1:0];
				default: ;
			endcase
		end
		// Unmasked new errors are reported by severity
		uncor_next = enable_reg && |(new_set & ~mask_reg & sev_reg); // see RULE5 see RULE6
		cor_next   = enable_reg && |(new_set & ~mask_reg & ~sev_reg); // see RULE6
		// Real headers are never captured, so the log takes all ones
		if (uncor_next && !uem_reg[AER_UIE_BIT]) begin
			aer_sts_next[AER_UNCOR_BIT] = 1'b1; // see RULE6
			hdr_next                    = HDR_ONES; // see RULE3
		end
		if (cor_next && !cem_reg[AER_CIE_BIT])
			aer_sts_next[AER_COR_BIT] = 1'b1; // see RULE6
		// Read data, valid the cycle after the strobe
		// The test word is write-only and, like unmapped words, reads as zero
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFF_CONTROL:  rdata_next = {{(DATA_W-1){1'b0}}, enable_reg};
				OFF_STATUS:   rdata_next = {{(DATA_W-SRC_W){1'b0}}, status_reg};
				OFF_MASK:     rdata_next = {{(DATA_W-SRC_W){1'b0}}, mask_reg};
				OFF_SEVERITY: rdata_next = {{(DATA_W-SRC_W){1'b0}}, sev_reg};
				OFF_AER_UEM:  rdata_next = uem_reg;
				OFF_AER_UESV: rdata_next = uesv_reg;
				OFF_AER_CEM:  rdata_next = cem_reg;
				OFF_AER_STS:  rdata_next = {{(DATA_W-AER_W){1'b0}}, aer_sts_reg};
				OFF_HDR_LOG:  rdata_next = hdr_reg;
				default:      rdata_next = ZERO_WORD;
			endcase
		end
	end

	// Data path next values
	always_comb begin
		// Queue head discard and broadcast abort
		discard_next = timeout; // see RULE8
		abort_next   = timeout && bcast_active_i; // see RULE9
		// Ingress: parity computed on every received DWord, LCRC failure forces retry
		ing_next        = ing_beat_i;
		ing_next.parity = ^ing_beat_i.data; // see RULE17
		retry_next      = ing_lcrc_bad_i; // see RULE17
		// Incremental parity update carries any earlier error forward;
		// the parities of the old and new DWord fold into the carried bit
		modp_next = mod_valid_i ? (mod_par_i ^ (^mod_old_i) ^ (^mod_new_i)) : modp_reg; // see RULE18
		// Generated packets carry parity from the start
		gen_next.valid  = gen_valid_i;
		gen_next.sop    = 1'b0;
		gen_next.eop    = 1'b0;
		gen_next.data   = gen_data_i;
		gen_next.parity = ^gen_data_i; // see RULE22
		// Consumed packet: sticky bad flag until end, then discard
		// A start beat restarts the flag, so a lost end cannot spoil the next packet
		cbad_next = cbad_reg;
		cdis_next = 1'b0;
		if (con_beat_i.valid) begin
			if (con_beat_i.sop)
				cbad_next = con_bad_now;
			else
				cbad_next = cbad_reg | con_bad_now;
			if (con_beat_i.eop) begin
				cdis_next = cbad_next; // see RULE16 see RULE22
				cbad_next = 1'b0;
			end
		end
		// Egress: corrupt packet is nullified at its end
		ebad_next = ebad_reg;
		eend_next = '0;
		lcrc_next = lcrc_reg;
		flush_next = 1'b0;
		if (egr_beat_i.valid) begin
			if (egr_beat_i.sop)
				ebad_next = egr_bad_now;
			else
				ebad_next = ebad_reg | egr_bad_now;
			if (egr_beat_i.eop) begin
				// Nullify by an inverted LCRC and an EDB end on the same frame
				eend_next.valid   = 1'b1;
				eend_next.nullify = ebad_next; // see RULE14 see RULE20
				eend_next.end_edb = ebad_next;
				lcrc_next  = ebad_next ? ~egr_lcrc_i : egr_lcrc_i; // see RULE14
				ebad_next  = 1'b0;
			end
		end
		// Replay keeps sequence numbers, so a bad replay flushes everything
		flush_next = replay_active_i && egr_beat_i.valid && egr_bad_now; // see RULE15 see RULE21
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			// Register file and reports
			enable_reg  <= 1'b0;
			status_reg  <= '0;
			mask_reg    <= MASK_RST;
			sev_reg     <= SEV_RST;
			uem_reg     <= AER_UEM_RST;
			uesv_reg    <= AER_UESV_RST;
			cem_reg     <= AER_CEM_RST;
			aer_sts_reg <= '0;
			hdr_reg     <= ZERO_WORD;
			rdata_reg   <= ZERO_WORD;
			uncor_reg   <= 1'b0;
			cor_reg     <= 1'b0;
			// Data path
			discard_reg <= 1'b0;
			abort_reg   <= 1'b0;
			ing_reg     <= '0;
			retry_reg   <= 1'b0;
			modp_reg    <= 1'b0;
			gen_reg     <= '0;
			cdis_reg    <= 1'b0;
			cbad_reg    <= 1'b0;
			ebad_reg    <= 1'b0;
			eend_reg    <= '0;
			lcrc_reg    <= '0;
			flush_reg   <= 1'b0;
		end else begin
			// Register file and reports
			enable_reg  <= enable_next;
			status_reg  <= status_next;
			mask_reg    <= mask_next;
			sev_reg     <= sev_next;
			uem_reg     <= uem_next;
			uesv_reg    <= uesv_next;
			cem_reg     <= cem_next;
			aer_sts_reg <= aer_sts_next;
			hdr_reg     <= hdr_next;
			rdata_reg   <= rdata_next;
			uncor_reg   <= uncor_next;
			cor_reg     <= cor_next;
			// Data path
			discard_reg <= discard_next;
			abort_reg   <= abort_next;
			ing_reg     <= ing_next;
			retry_reg   <= retry_next;
			modp_reg    <= modp_next;
			gen_reg     <= gen_next;
			cdis_reg    <= cdis_next;
			cbad_reg    <= cbad_next;
			ebad_reg    <= ebad_next;
			eend_reg    <= eend_next;
			lcrc_reg    <= lcrc_next;
			flush_reg   <= flush_next;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_o    = rdata_reg;
	assign uncor_report_o = uncor_reg;
	assign cor_report_o   = cor_reg;

	// Data path outputs
	assign head_discard_o = discard_reg;
	assign bcast_abort_o  = abort_reg;
	assign ing_beat_o     = ing_reg;
	assign ing_retry_o    = retry_reg;
	assign mod_par_o      = modp_reg;
	assign gen_beat_o     = gen_reg;
	assign con_discard_o  = cdis_reg;
	assign egr_end_o      = eend_reg;
	assign egr_lcrc_o     = lcrc_reg;
	assign replay_flush_o = flush_reg;

endmodule

`default_nettype wire

// File: bench/internal_error_ecc_parity_monitor.sv
// Port checker for the per-port internal error block
`timescale 1ns/100ps
`default_nettype none
module internal_error_ecc_parity_monitor
	import int_err_pkg::*;
#(
	parameter longint AGE_LIMIT_CYCLES = AGE_LIMIT_CY
) (
	// Clock and reset
	input wire logic             clk_i,
	input wire logic             rst_b_i,
	// Queue heads
	input wire logic             head_valid_i,
	input wire logic [AGE_W-1:0] head_age_i,
	input wire logic             bcast_active_i,
	input wire logic             head_discard_o,
	input wire logic             bcast_abort_o,
	// Ingress, modify and generate paths
	input wire dw_beat_t         ing_beat_i,
	input wire logic             ing_lcrc_bad_i,
	input wire dw_beat_t         ing_beat_o,
	input wire logic             ing_retry_o,
	input wire logic             mod_valid_i,
	input wire logic [31:0]      mod_old_i,
	input wire logic [31:0]      mod_new_i,
	input wire logic             mod_par_i,
	input wire logic             mod_par_o,
	input wire logic             gen_valid_i,
	input wire logic [31:0]      gen_data_i,
	input wire dw_beat_t         gen_beat_o,
	// Egress and reports
	input wire dw_beat_t         egr_beat_i,
	input wire logic [31:0]      egr_lcrc_i,
	input wire egr_end_t         egr_end_o,
	input wire logic [31:0]      egr_lcrc_o,
	input wire logic             uncor_report_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// Aged heads and broadcast aborts follow the age compare by one cycle
	AST_AGE_DISCARD: assert property (head_discard_o == $past(head_valid_i && (head_age_i > AGE_LIMIT_CYCLES)))
		else $error("head discard does not follow age limit");
	AST_BCAST_ABORT: assert property (bcast_abort_o == $past(head_valid_i && (head_age_i > AGE_LIMIT_CYCLES) && bcast_active_i))
		else $error("broadcast abort wrong");
	// Parity, retry and nullify paths
	AST_ING_PARITY: assert property (ing_beat_i.valid |=> ing_beat_o.valid && ing_beat_o.parity == ^$past(ing_beat_i.data))
		else $error("ingress parity wrong");
	AST_LCRC_RETRY: assert property (ing_lcrc_bad_i |=> ing_retry_o)
		else $error("no retry after bad link crc");
	AST_MOD_PARITY: assert property (mod_valid_i |=> mod_par_o == ($past(mod_par_i) ^ ^$past(mod_old_i) ^ ^$past(mod_new_i)))
		else $error("incremental parity wrong");
	AST_MOD_HOLD: assert property (!mod_valid_i |=> $stable(mod_par_o))
		else $error("parity changed without update");
	AST_GEN_PARITY: assert property (gen_valid_i |=> gen_beat_o.valid && gen_beat_o.parity == ^$past(gen_data_i))
		else $error("generated parity wrong");
	AST_EGR_END: assert property (egr_beat_i.valid && egr_beat_i.eop |=> egr_end_o.valid)
		else $error("no frame end after last beat");
	AST_NULL_LCRC: assert property (egr_end_o.valid |-> egr_end_o.end_edb == egr_end_o.nullify && egr_lcrc_o == ($past(egr_lcrc_i) ^ {32{egr_end_o.nullify}}))
		else $error("nullify crc or end wrong");

	// Main scenarios reached
	COV_DISCARD: cover property (head_discard_o);
	COV_NULLIFY: cover property (egr_end_o.nullify);
	COV_UNCOR: cover property (uncor_report_o);
endmodule
bind internal_error_ecc_parity internal_error_ecc_parity_monitor #(.AGE_LIMIT_CYCLES(AGE_LIMIT_CYCLES)) i_mon (.*);
`default_nettype wire

// File: bench/link_partner_model.sv
// Link partner model that keeps or drops frames at their end
`timescale 1ns/100ps
`default_nettype none
module link_partner_model
	import int_err_pkg::*;
(
	// Clock and reset
	input  wire logic     clk_i,
	input  wire logic     rst_b_i,
	// Frame end seen on the link
	input  wire egr_end_t egr_end_i,
	// Tallies of received frames
	output var  int       accepted_o,
	output var  int       dropped_o
);
	// Frames whose end carries both nullify and an EDB end are thrown away
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			accepted_o <= 0;
			dropped_o <= 0;
		end else if (egr_end_i.valid && egr_end_i.nullify && egr_end_i.end_edb) begin
			dropped_o <= dropped_o + 1;
		end else if (egr_end_i.valid) begin
			accepted_o <= accepted_o + 1;
		end
	end
endmodule
`default_nettype wire

// File: bench/tb_internal_error_ecc_parity.sv
// Self-checking bench for the per-port internal error block
`timescale 1ns/100ps
`default_nettype none
module tb_internal_error_ecc_parity
	import int_err_pkg::*;
;
	localparam longint LIM = 20;
	logic clk_i, rst_b_i, reg_wr_i, reg_rd_i, head_valid_i, bcast_active_i, ing_lcrc_bad_i, mod_valid_i;
	logic mod_par_i, gen_valid_i, con_dbe_i, egr_data_dbe_i, replay_active_i, head_discard_o, bcast_abort_o;
	logic ing_retry_o, mod_par_o, con_discard_o, replay_flush_o, uncor_report_o, cor_report_o;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
	logic [AGE_W-1:0]  head_age_i;
	logic [31:0]       mod_old_i, mod_new_i, gen_data_i, egr_lcrc_i, egr_lcrc_o, d, r;
	mem_err_t          mem_err_i;
	dw_beat_t          ing_beat_i, ing_beat_o, gen_beat_o, con_beat_i, egr_beat_i;
	egr_end_t          egr_end_o;
	logic [6:0]        msk = 7'h04;
	logic [6:0]        sev = 7'h7d;
	int num_errors, comparisons, seed, drops, accepts, exp_drops, k;
	logic [ADDR_W-1:0] ra [8] = '{OFF_CONTROL, OFF_MASK, OFF_SEVERITY, OFF_TEST, OFF_AER_UEM, OFF_AER_UESV, OFF_AER_CEM, 4'hf};
	logic [DATA_W-1:0] rv [8] = '{ZERO_WORD, 32'(MASK_RST), 32'(SEV_RST), ZERO_WORD, AER_UEM_RST, AER_UESV_RST, AER_CEM_RST, ZERO_WORD};
	logic [2:0]        ec [5] = '{3'h0, 3'h4, 3'h2, 3'h5, 3'h3};

	internal_error_ecc_parity #(.AGE_LIMIT_CYCLES(LIM)) i_internal_error_ecc_parity (.*);
	link_partner_model i_link_partner_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .egr_end_i(egr_end_o),
		.accepted_o(accepts), .dropped_o(drops));

	// Comparisons of words and single bits
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t word %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t bit %b expected %b", $time, g, e);
		end
	endtask
	// Register port cycles
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 chk32(reg_rdata_o, e);
	endtask
	// Report pulse from the model's mask and severity, then status read and clear
	task automatic rep(input int b);
		#1 chk1(uncor_report_o, !msk[b] && sev[b]);
		chk1(cor_report_o, !msk[b] && !sev[b]);
		rd(OFF_STATUS, 32'h1 << b);
		wr(OFF_STATUS, 32'h1 << b);
	endtask
	// Two-beat egress frame with optional faults on the first beat
	task automatic egr(input logic bp, input logic dbe, input logic rp);
		d = $random(seed);
		@(posedge clk_i);
		egr_beat_i <= {3'b110, d, ^d ^ bp};
		egr_data_dbe_i <= dbe;
		replay_active_i <= rp;
		@(posedge clk_i);
		egr_beat_i <= {3'b101, ~d, ^d};
		egr_data_dbe_i <= 1'b0;
		egr_lcrc_i <= d;
		#1 chk1(replay_flush_o, rp && (bp || dbe));
		@(posedge clk_i);
		egr_beat_i <= '0;
		replay_active_i <= 1'b0;
		#1 chk1(egr_end_o.end_edb, bp || dbe);
		chk32(egr_lcrc_o, (bp || dbe) ? ~d : d);
		exp_drops += int'(bp || dbe);
	endtask
	// Single-beat frame consumed inside the switch
	task automatic con(input logic bp, input logic dbe);
		d = $random(seed);
		@(posedge clk_i);
		con_beat_i <= {3'b111, d, ^d ^ bp};
		con_dbe_i <= dbe;
		@(posedge clk_i);
		con_beat_i <= '0;
		con_dbe_i <= 1'b0;
		#1 chk1(con_discard_o, bp || dbe);
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#60000;
		num_errors++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		seed = 4512;
		rst_b_i <= 1'b0;
		{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, head_valid_i, head_age_i, bcast_active_i, mem_err_i, ing_beat_i,
			ing_lcrc_bad_i, mod_valid_i, mod_old_i, mod_new_i, mod_par_i, gen_valid_i, gen_data_i, con_beat_i,
			con_dbe_i, egr_beat_i, egr_data_dbe_i, replay_active_i, egr_lcrc_i} <= '0;
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (k = 0; k < 8; k++) rd(ra[k], rv[k]);
		wr(OFF_AER_UEM, '0);
		wr(OFF_AER_CEM, '0);
		wr(OFF_AER_UESV, '0);
		rd(OFF_AER_UESV, AER_UESV_RST);
		rd(OFF_AER_UEM, AER_UEM_RST);
		rd(OFF_AER_CEM, AER_CEM_RST);
		wr(OFF_CONTROL, 32'h1);
		wr(OFF_AER_UEM, '0);
		wr(OFF_AER_CEM, '0);
		rd(OFF_AER_CEM, '0);
		wr(OFF_TEST, '0);
		rd(OFF_STATUS, '0);
		wr(OFF_MASK, 32'(msk));
		wr(OFF_SEVERITY, 32'(sev));
		for (k = 0; k < 3; k++) begin
			wr(OFF_TEST, 32'h1 << k);
			rep(k);
		end
		rd(OFF_AER_STS, 32'h3);
		rd(OFF_HDR_LOG, HDR_ONES);
		wr(OFF_AER_STS, 32'h3);
		rd(OFF_AER_STS, '0);
		for (k = 0; k < 2 * MEM_N; k++) begin
			@(posedge clk_i);
			mem_err_i <= (k < MEM_N) ? mem_err_t'(10'h20 << k) : mem_err_t'(10'h1 << (k - MEM_N));
			@(posedge clk_i);
			mem_err_i <= '0;
			rep(k % MEM_N + 1);
		end
		@(posedge clk_i);
		mem_err_i <= '1;
		@(posedge clk_i);
		mem_err_i <= '0;
		rd(OFF_STATUS, 32'h3e);
		wr(OFF_STATUS, 32'h3e);
		@(posedge clk_i);
		head_valid_i <= 1'b1;
		head_age_i <= AGE_W'(LIM);
		bcast_active_i <= 1'b1;
		@(posedge clk_i);
		head_age_i <= AGE_W'(LIM + 1);
		#1 chk1(head_discard_o, 1'b0);
		@(posedge clk_i);
		head_valid_i <= 1'b0;
		bcast_active_i <= 1'b0;
		#1 chk1(head_discard_o, 1'b1);
		chk1(bcast_abort_o, 1'b1);
		rep(SRC_TIMEOUT);
		for (k = 0; k < 5; k++) egr(ec[k][2], ec[k][1], ec[k][0]);
		rd(OFF_STATUS, 32'h40);
		wr(OFF_STATUS, 32'h40);
		for (k = 0; k < 3; k++) con(k == 1, k == 2);
		rd(OFF_STATUS, 32'h40);
		for (k = 0; k < 16; k++) begin
			d = $random(seed);
			r = $random(seed);
			@(posedge clk_i);
			ing_beat_i <= {3'b111, d, 1'b0};
			ing_lcrc_bad_i <= k[0];
			mod_valid_i <= 1'b1;
			mod_old_i <= d;
			mod_new_i <= r;
			mod_par_i <= k[1];
			gen_valid_i <= 1'b1;
			gen_data_i <= r;
			@(posedge clk_i);
			#1 chk1(ing_beat_o.parity, ^d);
			chk1(ing_retry_o, k[0]);
			chk1(mod_par_o, k[1] ^ (^d) ^ (^r));
			chk1(gen_beat_o.parity, ^r);
		end
		chk32(drops, exp_drops);
		chk32(accepts, 5 - exp_drops);
		report_and_stop();
	end
endmodule
`default_nettype wire
